// *** verilog/clk_ctrl_defs.svh ***
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// Clock source select codes
`define SEL_MULT 2'h0
`define SEL_OSC_A 2'h1
`define SEL_DIV4 2'h2
`define SEL_PMM 2'h3
`define SEL_RESET `SEL_DIV4

// Rates in mclk cycles, MCYC_DIV in system ticks; mclk is four times the oscillator
`define MCLK_PER_OSC 11'h004
`define DIV_X4 11'h001
`define DIV_X2 11'h002
`define DIV_OSC 11'h004
`define DIV_PMM 11'h400
`define MCYC_DIV 11'h004
`define PMM_MCYC_GAP 13'h0fff

// Multiplier settling, oscillator cycles
`define SETTLE_OSC_DEFAULT 65536

`endif

// *** verilog/clk_ctrl_pkg.sv ***
package clk_ctrl_pkg;
   typedef enum {MODE_MULT, MODE_OSC, MODE_PMM} clk_mode_e;
   typedef logic [1:0] sel_t;
   typedef logic [10:0] div_t;
endpackage

// *** verilog/tick_divider.sv ***
`timescale 1ns/1ps
module tick_divider (
   input wire logic mclk,
   input wire logic srst,
   input wire logic restart,
   input wire logic en_in,
   input wire clk_ctrl_pkg::div_t div,
   output logic tick_r
);
   clk_ctrl_pkg::div_t cnt_r;

   always_ff @(posedge mclk) begin
      if (srst || restart) begin
         cnt_r <= 11'h000;
         tick_r <= 1'b0;
      end else if (en_in) begin
         if (cnt_r >= div - 11'h001) begin
            cnt_r <= 11'h000;
            tick_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 11'h001;
            tick_r <= 1'b0;
         end
      end else begin
         tick_r <= 1'b0;
      end
   end
endmodule

// *** verilog/sys_clock_divide_control.sv ***
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"
// Behaviour
// - Two-bit select steers a three-way source mux: osc, osc/256, multiplied osc.
// - Selected system clock feeds peripherals; machine cycle is system clock over four.
// - Multiplier engaged only with multiplier enable set and select at 00.
// - Factor select 0 doubles, 1 quadruples the oscillator.
// - Engaged multiplier gives two or one oscillator clocks per machine cycle.
// - Select 11 enters power management: osc/256, machine cycle of 1024 osc clocks.
// - Power management clocks everything at osc/256 and keeps executing.
// - New rates apply at the first machine cycle boundary after the write.
// - Select changes must pass through 10; illegal writes leave the field unchanged.
// - Ready flag rises only after multiplier settling time since enable.
// - Divisor writes ignored while any serial port is active.
module sys_clock_divide_control #(
   parameter int SETTLE_OSC_CYCLES = `SETTLE_OSC_DEFAULT
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [1:0] wr_clock_source_select,
   input wire logic wr_multiplier_enable,
   input wire logic wr_multiply_factor_select,
   input wire logic serial_active,
   output logic clock_source_select_hi,
   output logic clock_source_select_lo,
   output logic multiplier_enable_r,
   output logic multiply_factor_select_r,
   output logic multiplier_ready_flag_r,
   output logic power_management_mode_r,
   output logic multiplier_engaged_r,
   output logic sys_clk_en_r,
   output logic mcyc_en_r
);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic clk_ctrl_pkg::clk_mode_e sel_mode(input clk_ctrl_pkg::sel_t sel);
      clk_ctrl_pkg::clk_mode_e m;
      m = clk_ctrl_pkg::MODE_OSC;
      if (sel == `SEL_MULT) begin
         m = clk_ctrl_pkg::MODE_MULT;
      end else if (sel == `SEL_PMM) begin
         m = clk_ctrl_pkg::MODE_PMM;
      end
      return m;
   endfunction

   function automatic logic sel_legal(input clk_ctrl_pkg::sel_t cur,
                                      input clk_ctrl_pkg::sel_t nxt);
      return (cur == nxt) || (cur == `SEL_DIV4) || (nxt == `SEL_DIV4);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   clk_ctrl_pkg::sel_t sel_r;
   clk_ctrl_pkg::sel_t active_sel_r;
   logic pending_r;
   logic osc_en;
   logic apply_now;
   logic sel_ok;
   logic sel_take;
   logic [16:0] settle_cnt_r;
   clk_ctrl_pkg::div_t sys_div;
   clk_ctrl_pkg::clk_mode_e active_mode;

   assign apply_now = mcyc_en_r && pending_r;
   assign active_mode = sel_mode(active_sel_r);
   // Entering 00 also needs a settled multiplier
   assign sel_ok = sel_legal(sel_r, wr_clock_source_select) &&
                   ((wr_clock_source_select != `SEL_MULT) || (sel_r == `SEL_MULT) ||
                    (multiplier_enable_r && multiplier_ready_flag_r));
   assign sel_take = wr_en && !serial_active && sel_ok &&
                     (wr_clock_source_select != sel_r);

   always_ff @(posedge mclk) begin
      if (srst) begin
         sel_r <= `SEL_RESET;
      end else if (sel_take) begin
         sel_r <= wr_clock_source_select;
      end
   end

   // Multiplier controls; dropping enable while at 00 would kill the live clock
   always_ff @(posedge mclk) begin
      if (srst) begin
         multiplier_enable_r <= 1'b0;
         multiply_factor_select_r <= 1'b0;
      end else if (wr_en) begin
         // A pending switch away from 00 still runs on the multiplier
         if (wr_multiplier_enable ||
             ((sel_r != `SEL_MULT) && (active_sel_r != `SEL_MULT))) begin
            multiplier_enable_r <= wr_multiplier_enable;
         end
         if (!multiplier_enable_r) begin
            multiply_factor_select_r <= wr_multiply_factor_select;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Settling counter runs on oscillator ticks while enabled
   always_ff @(posedge mclk) begin
      if (srst || !multiplier_enable_r) begin
         settle_cnt_r <= 17'h0_0000;
         multiplier_ready_flag_r <= 1'b0;
      end else if (osc_en && !multiplier_ready_flag_r) begin
         if (settle_cnt_r >= 17'(SETTLE_OSC_CYCLES - 1)) begin
            multiplier_ready_flag_r <= 1'b1;
         end else begin
            settle_cnt_r <= settle_cnt_r + 17'h0_0001;
         end
      end
   end

   // A write arriving on the apply tick stays pending for the next one
   always_ff @(posedge mclk) begin
      if (srst) begin
         pending_r <= 1'b0;
         active_sel_r <= `SEL_RESET;
      end else begin
         if (sel_take) begin
            pending_r <= 1'b1;
         end else if (apply_now) begin
            pending_r <= 1'b0;
         end
         if (apply_now) begin
            active_sel_r <= sel_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      sys_div = `DIV_OSC;
      case (active_mode)
         clk_ctrl_pkg::MODE_MULT: begin
            sys_div = multiply_factor_select_r ? `DIV_X4 : `DIV_X2;
         end
         clk_ctrl_pkg::MODE_PMM: begin
            sys_div = `DIV_PMM;
         end
         default: begin
            sys_div = `DIV_OSC;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         multiplier_engaged_r <= 1'b0;
         power_management_mode_r <= 1'b0;
         clock_source_select_hi <= 1'b1;
         clock_source_select_lo <= 1'b0;
      end else begin
         multiplier_engaged_r <= (active_sel_r == `SEL_MULT) && multiplier_enable_r;
         power_management_mode_r <= (active_sel_r == `SEL_PMM);
         clock_source_select_hi <= sel_r[1];
         clock_source_select_lo <= sel_r[0];
      end
   end

   // System and machine-cycle dividers restart on a rate change to avoid a runt tick; the oscillator divider free-runs
   tick_divider u_osc (
      .mclk(mclk), .srst(srst), .restart(1'b0), .en_in(1'b1),
      .div(`MCLK_PER_OSC), .tick_r(osc_en)
   );
   tick_divider u_sys (
      .mclk(mclk), .srst(srst), .restart(apply_now), .en_in(1'b1),
      .div(sys_div), .tick_r(sys_clk_en_r)
   );
   tick_divider u_mcyc (
      .mclk(mclk), .srst(srst), .restart(apply_now), .en_in(sys_clk_en_r),
      .div(`MCYC_DIV), .tick_r(mcyc_en_r)
   );

   ////////////////////////////////////////////////////////////////////////////////
   logic [12:0] gap_r;
   logic last_pmm_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         gap_r <= 13'h0000;
         last_pmm_r <= 1'b0;
      end else if (mcyc_en_r) begin
         gap_r <= 13'h0000;
         last_pmm_r <= (active_sel_r == `SEL_PMM) && !apply_now;
      end else if (gap_r != 13'h1fff) begin
         gap_r <= gap_r + 13'h0001;
      end
   end

   a_illegal_sel_kept: assert property (@(posedge mclk) disable iff (srst)
      (wr_en && !sel_legal(sel_r, wr_clock_source_select)) |=> $stable(sel_r))
      else $error("illegal select transition was taken");
   a_serial_lockout: assert property (@(posedge mclk) disable iff (srst)
      (wr_en && serial_active) |=> $stable(sel_r))
      else $error("select changed during serial activity");
   a_engage_cond: assert property (@(posedge mclk) disable iff (srst)
      multiplier_engaged_r |-> ($past(active_sel_r) == `SEL_MULT && $past(multiplier_enable_r)))
      else $error("multiplier engaged without enable and code 00");
   a_x4_rate: assert property (@(posedge mclk) disable iff (srst)
      (mcyc_en_r && !apply_now && active_sel_r == `SEL_MULT && multiply_factor_select_r)
      |=> !mcyc_en_r [*3] ##1 mcyc_en_r)
      else $error("x4 machine cycle is not four mclk");
   a_x2_rate: assert property (@(posedge mclk) disable iff (srst)
      // A restart right after this tick stretches one gap, so pending writes are excluded
      (sys_clk_en_r && !pending_r && !sel_take && active_sel_r == `SEL_MULT &&
       !multiply_factor_select_r)
      |=> !sys_clk_en_r ##1 sys_clk_en_r)
      else $error("x2 system tick is not every second mclk");
   a_osc_rate: assert property (@(posedge mclk) disable iff (srst)
      (sys_clk_en_r && !pending_r && !sel_take &&
       (active_sel_r == `SEL_DIV4 || active_sel_r == `SEL_OSC_A))
      |=> !sys_clk_en_r [*3] ##1 sys_clk_en_r)
      else $error("undivided oscillator tick spacing wrong");
   a_pmm_cycle: assert property (@(posedge mclk) disable iff (srst)
      (mcyc_en_r && last_pmm_r) |-> (gap_r == `PMM_MCYC_GAP))
      else $error("power management machine cycle length wrong");
   a_rate_deferred: assert property (@(posedge mclk) disable iff (srst)
      !apply_now |=> $stable(active_sel_r))
      else $error("rate changed outside a machine cycle boundary");
   a_ready_settled: assert property (@(posedge mclk) disable iff (srst)
      $rose(multiplier_ready_flag_r) |-> multiplier_enable_r &&
      ($past(settle_cnt_r) >= 17'(SETTLE_OSC_CYCLES - 1)))
      else $error("ready flag rose before settling");
endmodule

// *** verification/tb_sys_clock_divide_control.sv ***
`timescale 1ns/1ps
module tb_sys_clock_divide_control;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic wr_en = 1'b0;
   logic [1:0] wsel = 2'h2;
   logic wme = 1'b0;
   logic wfs = 1'b0;
   logic ser = 1'b0;
   logic hi, lo, me, fs, rdy, power_management_mode, eng, sen, men;
   int mismatches = 0;
   int total_checks = 0;
   int g;

   // Tick rates are relative; the board keeps the real system clock within limit
   initial begin
      forever #2.5 mclk = ~mclk;
   end

   // Short settling count keeps the run brief
   sys_clock_divide_control #(.SETTLE_OSC_CYCLES(8)) u_sys_clock_divide_control (
      .mclk(mclk), .srst(srst), .wr_en(wr_en), .wr_clock_source_select(wsel),
      .wr_multiplier_enable(wme), .wr_multiply_factor_select(wfs), .serial_active(ser),
      .clock_source_select_hi(hi), .clock_source_select_lo(lo), .multiplier_enable_r(me),
      .multiply_factor_select_r(fs), .multiplier_ready_flag_r(rdy),
      .power_management_mode_r(power_management_mode), .multiplier_engaged_r(eng), .sys_clk_en_r(sen),
      .mcyc_en_r(men));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask

   // Spacing between two pulses; sampled at negedge, away from the launch edge
   task automatic gap(input logic m, output int n);
      n = 0;
      @(negedge mclk);
      while ((m ? men : sen) !== 1'b1 && n < 5000) begin
         @(negedge mclk);
         n++;
      end
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while ((m ? men : sen) !== 1'b1 && n < 5000);
   endtask

   // Two machine cycles cover a write landing on an apply tick
   task automatic wr(input logic [1:0] s, input logic e, input logic f, input bit w);
      int n;
      @(posedge mclk);
      wr_en <= 1'b1;
      wsel <= s;
      wme <= e;
      wfs <= f;
      @(posedge mclk);
      wr_en <= 1'b0;
      if (w) begin
         gap(1'b1, n);
         gap(1'b1, n);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("sel", {hi, lo}, 2'h2);
      check("ctl", {me, fs, rdy, power_management_mode, eng}, 5'h00);
      gap(1'b0, g);
      check("sys_gap", g, 4);
      gap(1'b1, g);
      check("mcyc_gap", g, 16);
   endtask

   task automatic t_refuse();
      wr(2'h0, 1'b0, 1'b0, 1'b1);
      check("sel", {hi, lo}, 2'h2);
      @(posedge mclk);
      ser <= 1'b1;
      wr(2'h3, 1'b0, 1'b0, 1'b1);
      check("sel", {hi, lo}, 2'h2);
      check("pmm", power_management_mode, 1'b0);
      @(posedge mclk);
      ser <= 1'b0;
      wr(2'h1, 1'b0, 1'b0, 1'b1);
      check("sel", {hi, lo}, 2'h1);
      gap(1'b0, g);
      check("sys_gap", g, 4);
      wr(2'h3, 1'b0, 1'b0, 1'b1);
      check("sel", {hi, lo}, 2'h1);
   endtask

   task automatic t_pmm();
      wr(2'h2, 1'b0, 1'b0, 1'b1);
      wr(2'h3, 1'b0, 1'b0, 1'b1);
      check("sel", {hi, lo}, 2'h3);
      check("pmm", power_management_mode, 1'b1);
      gap(1'b0, g);
      check("sys_gap", g, 1024);
      gap(1'b1, g);
      check("mcyc_gap", g, 4096);
      wr(2'h0, 1'b1, 1'b0, 1'b1);
      check("sel", {hi, lo}, 2'h3);
      wr(2'h2, 1'b0, 1'b0, 1'b1);
      check("pmm", power_management_mode, 1'b0);
   endtask

   task automatic t_mult(input logic f, input int exp);
      int n;
      wr(2'h2, 1'b0, f, 1'b1);
      check("rdy", rdy, 1'b0);
      wr(2'h2, 1'b1, f, 1'b0);
      n = 0;
      while (rdy !== 1'b1 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      // Eight oscillator ticks of four mclk each, plus phase of the first tick
      check("rdy_wait", n >= 29 && n <= 33, 1'b1);
      check("me", me, 1'b1);
      check("eng", eng, 1'b0);
      wr(2'h0, 1'b1, f, 1'b1);
      check("eng", {hi, lo, eng, fs}, {3'h1, f});
      gap(1'b0, g);
      check("sys_gap", g, exp);
      gap(1'b1, g);
      check("mcyc_gap", g, 4 * exp);
      wr(2'h3, 1'b0, f, 1'b1);
      check("keep", {hi, lo, me, eng}, 4'h3);
      wr(2'h2, 1'b1, f, 1'b1);
      check("eng", {hi, lo, eng}, 3'h4);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      t_reset();
      t_refuse();
      t_pmm();
      t_mult(1'b0, 2);
      t_mult(1'b1, 1);
      test_done();
   end

   // Whole sequence needs roughly 42000 cycles, mostly in power management
   initial begin
      #400us;
      mismatches++;
      test_done();
   end
endmodule
